// >>> rtl/laser_setpoint_pkg.sv
/*
 Package for the laser drive setpoint register slice: command codes,
 field positions, reset values and derived current constants.
 Assumes a serial command decoder upstream that presents word accesses.
*/
package laser_setpoint_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0]  CMD_FACTORY_TEST  = 8'h08;
	localparam logic [7:0]  CMD_BIAS_SETPOINT = 8'h15;
	localparam logic [7:0]  CMD_EDGE_TRIM     = 8'h1F;
	// ==========================================================
	// Widths and field positions
	localparam int          REG_W        = 16;
	localparam int          TRIM_W       = 5;
	localparam int          TRIM_LSB     = 0;
	localparam int          RANGE_W      = 2;
	localparam int          RANGE_LSB    = 10;
	localparam int          NOM_W        = 10;
	localparam int          NOM_LSB      = 0;
	localparam int          TEST_W       = 7;
	// ==========================================================
	// Reset values
	localparam logic [4:0]  TRIM_RST     = 5'h10;
	localparam logic [6:0]  TEST_RST     = 7'h44;
	localparam logic [1:0]  RANGE_RST    = 2'h0;
	localparam logic [9:0]  NOM_RST      = 10'h000;
	// ==========================================================
	// Current scaling: full scale step per range code, in microamps
	localparam int          RANGE_STEP_UA = 9000;
	localparam int          NOM_DIV       = 1024;
	localparam int          CUR_W         = 16;
endpackage

// >>> rtl/setpoint_current_calc.sv
/*
 Converts the setpoint and range select into a bias current target in
 microamps: nominal / 1024 * (range + 1) * 9 mA.
 Assumes inputs are registered; output is registered one cycle later.
*/
module setpoint_current_calc
	import laser_setpoint_pkg::*;
(
	// Clock and reset
	input  wire logic                               i_core_clk,
	input  wire logic                               i_sys_rst,
	// Setpoint
	input  wire logic [laser_setpoint_pkg::NOM_W-1:0]   i_nominal,
	input  wire logic [laser_setpoint_pkg::RANGE_W-1:0] i_range,
	// Result
	output logic      [laser_setpoint_pkg::CUR_W-1:0]   o_current_ua
);
	logic [CUR_W-1:0] cur_reg;
	logic [CUR_W-1:0] cur_next;
	logic [31:0]      prod;

	always_comb begin
		prod = 32'(i_nominal) * (32'(i_range) + 32'h1) * 32'(RANGE_STEP_UA);
		cur_next = CUR_W'(prod / 32'(NOM_DIV));
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign o_current_ua = cur_reg;
endmodule

// >>> rtl/laser_drive_setpoint_regs.sv
/*
 Setpoint register slice of a laser driver control bank: edge trim,
 factory test and bias / monitor diode setpoint registers.
 Assumes a serial front end delivering command code, write strobe and
 16-bit data synchronous to i_core_clk; read data is combinational.
*/
// Functional notes
// - Five-bit edge trim, resets to 0x10
// - Lower trim gives more falling undershoot
// - Test register resets with bits 6,2
// - Two-bit range select, 9 to 36 mA
// - Ten-bit unsigned nominal setpoint, reset zero
// - Loop select picks bias or monitor target
// - Bias current is nom/1024*(range+1)*9mA with loop select 0, zero with loop select 1
module laser_drive_setpoint_regs
	import laser_setpoint_pkg::*;
(
	// Clock and reset
	input  wire logic                                   i_core_clk,
	input  wire logic                                   i_sys_rst,
	// Register access from the serial command decoder
	input  wire logic [7:0]                             i_cmd_code,
	input  wire logic                                   i_wr_en,
	input  wire logic [laser_setpoint_pkg::REG_W-1:0]   i_wr_data,
	output logic      [laser_setpoint_pkg::REG_W-1:0]   o_rd_data,
	output logic                                        o_cmd_hit,
	// Power loop select: 0 bias current, 1 monitor diode
	input  wire logic                                   i_loop_sel,
	// Analog control outputs
	output logic      [laser_setpoint_pkg::TRIM_W-1:0]  o_edge_trim,
	output logic      [laser_setpoint_pkg::RANGE_W-1:0] o_source_range_sel,
	output logic      [laser_setpoint_pkg::NOM_W-1:0]   o_bias_target,
	output logic      [laser_setpoint_pkg::NOM_W-1:0]   o_monitor_target,
	output logic      [laser_setpoint_pkg::CUR_W-1:0]   o_bias_current_ua,
	output logic      [laser_setpoint_pkg::TEST_W-1:0]  o_factory_test
);
	import laser_setpoint_pkg::*;

	// ==========================================================
	// Register state
	logic [TRIM_W-1:0]  trim_reg,  trim_next;
	logic [TEST_W-1:0]  test_reg,  test_next;
	logic [RANGE_W-1:0] range_reg, range_next;
	logic [NOM_W-1:0]   nom_reg,   nom_next;
	logic [NOM_W-1:0]   bias_reg,  bias_next;
	logic [NOM_W-1:0]   mon_reg,   mon_next;

	always_comb begin
		trim_next  = trim_reg;
		test_next  = test_reg;
		range_next = range_reg;
		nom_next   = nom_reg;
		if (i_wr_en) begin
			case (i_cmd_code)
				CMD_EDGE_TRIM: begin
					trim_next = i_wr_data[TRIM_LSB +: TRIM_W];
				end
				CMD_FACTORY_TEST: begin
					// Writable for test access only; normal hosts leave it alone
					test_next = i_wr_data[TEST_W-1:0];
				end
				CMD_BIAS_SETPOINT: begin
					range_next = i_wr_data[RANGE_LSB +: RANGE_W];
					nom_next   = i_wr_data[NOM_LSB +: NOM_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Route the setpoint to the loop the mode select picks
	always_comb begin
		bias_next = bias_reg;
		mon_next  = mon_reg;
		if (i_loop_sel) begin
			mon_next  = nom_next;
			bias_next = NOM_RST;
		end else begin
			bias_next = nom_next;
			mon_next  = NOM_RST;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			trim_reg  <= TRIM_RST;
			test_reg  <= TEST_RST;
			range_reg <= RANGE_RST;
			nom_reg   <= NOM_RST;
			bias_reg  <= NOM_RST;
			mon_reg   <= NOM_RST;
		end else begin
			trim_reg  <= trim_next;
			test_reg  <= test_next;
			range_reg <= range_next;
			nom_reg   <= nom_next;
			bias_reg  <= bias_next;
			mon_reg   <= mon_next;
		end
	end

	// ==========================================================
	// Read-back: reserved upper bits as zero
	always_comb begin
		o_rd_data = '0;
		o_cmd_hit = 1'b1;
		case (i_cmd_code)
			CMD_EDGE_TRIM:     o_rd_data = REG_W'(trim_reg);
			CMD_FACTORY_TEST:  o_rd_data = REG_W'(test_reg);
			CMD_BIAS_SETPOINT: o_rd_data = REG_W'({range_reg, nom_reg});
			default:           o_cmd_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Outputs; trim is a straight code, smaller value means more undershoot
	assign o_edge_trim        = trim_reg;
	assign o_source_range_sel = range_reg;
	assign o_bias_target      = bias_reg;
	assign o_monitor_target   = mon_reg;
	assign o_factory_test     = test_reg;

	setpoint_current_calc u_calc (
		.i_core_clk   (i_core_clk),
		.i_sys_rst    (i_sys_rst),
		.i_nominal    (bias_reg),
		.i_range      (range_reg),
		.o_current_ua (o_bias_current_ua)
	);

	// ==========================================================
	// Assertions: write paths
	a_trim_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_wr_en && i_cmd_code == CMD_EDGE_TRIM
		|=> o_edge_trim == $past(i_wr_data[TRIM_LSB +: TRIM_W]))
		else $error("edge trim not updated");
	a_trim_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!(i_wr_en && i_cmd_code == CMD_EDGE_TRIM) |=> $stable(o_edge_trim))
		else $error("edge trim changed without write");
	a_test_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_wr_en && i_cmd_code == CMD_FACTORY_TEST
		|=> o_factory_test == $past(i_wr_data[TEST_W-1:0]))
		else $error("test register not updated");
	a_test_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!(i_wr_en && i_cmd_code == CMD_FACTORY_TEST) |=> $stable(o_factory_test))
		else $error("test register changed without write");
	a_range_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT
		|=> o_source_range_sel == $past(i_wr_data[RANGE_LSB +: RANGE_W]))
		else $error("range select not updated");
	a_range_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!(i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT) |=> $stable(o_source_range_sel))
		else $error("range select changed without write");
	a_nom_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT
		|=> nom_reg == $past(i_wr_data[NOM_LSB +: NOM_W]))
		else $error("nominal setpoint not updated");
	a_nom_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!(i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT) |=> $stable(nom_reg))
		else $error("nominal setpoint changed without write");

	// ==========================================================
	// Assertions: reset values
	a_reset_values: assert property (@(posedge i_core_clk)
		i_sys_rst |-> o_edge_trim == TRIM_RST && o_factory_test == TEST_RST
		&& o_source_range_sel == RANGE_RST && nom_reg == NOM_RST
		&& o_bias_target == NOM_RST && o_monitor_target == NOM_RST
		&& o_bias_current_ua == '0)
		else $error("register not at reset value");

	// ==========================================================
	// Assertions: loop routing and current
	a_nom_route: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT && !i_loop_sel
		|=> o_bias_target == $past(i_wr_data[9:0]) && o_monitor_target == 10'h000)
		else $error("bias target wrong");
	a_mon_route: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT && i_loop_sel
		|=> o_monitor_target == $past(i_wr_data[9:0]) && o_bias_target == 10'h000)
		else $error("monitor target wrong");
	a_loop_route: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!(i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT) |=> ($past(i_loop_sel)
			? o_monitor_target == $past(nom_reg) && o_bias_target == NOM_RST
			: o_bias_target == $past(nom_reg) && o_monitor_target == NOM_RST))
		else $error("loop routing wrong");
	a_current_calc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		##1 o_bias_current_ua == CUR_W'((32'($past(o_bias_target)) *
			(32'($past(o_source_range_sel)) + 32'h1) * 32'(RANGE_STEP_UA)) / 32'(NOM_DIV)))
		else $error("bias current mismatch");

	// ==========================================================
	// Assertions: read-back and decode
	a_trim_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cmd_code == CMD_EDGE_TRIM |-> o_rd_data[TRIM_LSB +: TRIM_W] == o_edge_trim)
		else $error("edge trim read-back wrong");
	a_test_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cmd_code == CMD_FACTORY_TEST |-> o_rd_data[TEST_W-1:0] == o_factory_test)
		else $error("test register read-back wrong");
	a_setpt_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cmd_code == CMD_BIAS_SETPOINT |-> o_rd_data[NOM_LSB +: NOM_W] == nom_reg
		&& o_rd_data[RANGE_LSB +: RANGE_W] == o_source_range_sel)
		else $error("setpoint read-back wrong");
	a_rsvd_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cmd_code == CMD_EDGE_TRIM |-> o_rd_data[REG_W-1:TRIM_W] == '0)
		else $error("trim reserved bits not zero");
	a_rsvd_test: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cmd_code == CMD_FACTORY_TEST |-> o_rd_data[REG_W-1:TEST_W] == '0)
		else $error("test reserved bits not zero");
	a_rsvd_setpt: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cmd_code == CMD_BIAS_SETPOINT |-> o_rd_data[REG_W-1:RANGE_LSB+RANGE_W] == '0)
		else $error("setpoint reserved bits not zero");
	a_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!o_cmd_hit |-> o_rd_data == '0)
		else $error("unmapped read not zero");
	a_hit_decode: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		o_cmd_hit == (i_cmd_code == CMD_EDGE_TRIM || i_cmd_code == CMD_FACTORY_TEST
			|| i_cmd_code == CMD_BIAS_SETPOINT))
		else $error("command decode wrong");

	// ==========================================================
	// Coverage of the main scenarios
	c_trim_wr: cover property (@(posedge i_core_clk) i_wr_en && i_cmd_code == CMD_EDGE_TRIM);
	c_set_ccc: cover property (@(posedge i_core_clk) i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT
		&& !i_loop_sel);
	c_set_apc: cover property (@(posedge i_core_clk) i_wr_en && i_cmd_code == CMD_BIAS_SETPOINT
		&& i_loop_sel);
	c_unmapped: cover property (@(posedge i_core_clk) !o_cmd_hit);
	c_loop_swap: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) $changed(i_loop_sel));
endmodule

// >>> bench/host_model.sv
/*
 Host model: issues register writes and reads by command code; writes to CMD_FACTORY_TEST are dropped.
 Assumes the bench owns the clock; drives only on its falling edge.
*/
module host_model (
	// Clock
	input  wire logic                              i_core_clk,
	// Register access
	output logic      [7:0]                        o_cmd_code,
	output logic                                   o_wr_en,
	output logic      [laser_setpoint_pkg::REG_W-1:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import laser_setpoint_pkg::*;
	initial begin
		o_cmd_code = CMD_EDGE_TRIM;
		o_wr_en = 1'b0;
		o_wr_data = 16'h0000;
	end
	task automatic select(input logic [7:0] c);
		@(negedge i_core_clk);
		o_cmd_code = c;
		#1;
	endtask
	// Raw writes leave reserved bits as given
	task automatic write(input logic [7:0] c, input logic [15:0] d, input bit raw);
		if (c !== CMD_FACTORY_TEST) begin
			@(negedge i_core_clk);
			o_cmd_code = c;
			o_wr_data = raw ? d : d & (c == CMD_EDGE_TRIM ? 16'h001F : 16'h0FFF);
			o_wr_en = 1'b1;
			@(negedge i_core_clk);
			o_wr_en = 1'b0;
			#1;
		end
	endtask
endmodule

// >>> bench/laser_drive_setpoint_regs_bench.sv
/*
 Self-checking bench for the setpoint register slice.
 Assumes the host model drives all register access on falling edges.
*/
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module laser_drive_setpoint_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import laser_setpoint_pkg::*;
	logic        clk, rst, wr_en, hit, loop_sel, ls;
	logic [7:0]  cmd;
	logic [15:0] wr_data, rd_data, cur, d;
	logic [4:0]  trim;
	logic [1:0]  rng;
	logic [9:0]  bt, mt;
	logic [6:0]  ft;
	int          mismatches, checks, seed;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	host_model host_u (.i_core_clk(clk), .o_cmd_code(cmd), .o_wr_en(wr_en), .o_wr_data(wr_data));
	laser_drive_setpoint_regs dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_cmd_code(cmd),
		.i_wr_en(wr_en), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_cmd_hit(hit),
		.i_loop_sel(loop_sel), .o_edge_trim(trim), .o_source_range_sel(rng),
		.o_bias_target(bt), .o_monitor_target(mt), .o_bias_current_ua(cur),
		.o_factory_test(ft));
	function automatic logic [15:0] exp_cur(input logic [9:0] n, input logic [1:0] r);
		return 16'((32'(n) * (32'(r) + 32'h1) * 32'(RANGE_STEP_UA)) / 32'(NOM_DIV));
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Watchdog
	initial begin
		#10000;
		mismatches++;
		stop_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'h2B8E;
		rst = 1'b1;
		loop_sel = 1'b0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		host_u.select(CMD_EDGE_TRIM);
		`CHK("trim rd", 16'h0010, rd_data)
		`CHK("trim", 5'h10, trim)
		`CHK("trim hit", 1'b1, hit)
		host_u.select(CMD_FACTORY_TEST);
		`CHK("test rd", 16'h0044, rd_data)
		`CHK("test", 7'h44, ft)
		`CHK("test hit", 1'b1, hit)
		host_u.select(CMD_BIAS_SETPOINT);
		`CHK("sp rd", 16'h0000, rd_data)
		`CHK("sp hit", 1'b1, hit)
		`CHK("range", 2'h0, rng)
		host_u.select(8'h09);
		`CHK("unmapped rd", 16'h0000, rd_data)
		`CHK("unmapped hit", 1'b0, hit)
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
			host_u.write(CMD_EDGE_TRIM, d, i[0]);
			`CHK("trim rd", d & 16'h001F, rd_data)
			`CHK("trim", d[4:0], trim)
		end
		for (int i = 0; i < 24; i++) begin
			d = (i < 2) ? 16'hFFFF : 16'($random(seed));
			d[11:10] = i[1:0];
			ls = (i < 2) ? 1'b0 : 1'($random(seed));
			loop_sel = ls;
			host_u.write(CMD_BIAS_SETPOINT, d, i[0]);
			`CHK("sp rd", d & 16'h0FFF, rd_data)
			`CHK("range", d[11:10], rng)
			`CHK("bias tgt", ls ? 10'h000 : d[9:0], bt)
			`CHK("mon tgt", ls ? d[9:0] : 10'h000, mt)
			@(negedge clk);
			`CHK("current", exp_cur(ls ? 10'h000 : d[9:0], d[11:10]), cur)
			loop_sel = ~ls;
			repeat (2) @(negedge clk);
			`CHK("swap bias", ls ? d[9:0] : 10'h000, bt)
			`CHK("swap mon", ls ? 10'h000 : d[9:0], mt)
			`CHK("swap cur", exp_cur(ls ? d[9:0] : 10'h000, d[11:10]), cur)
		end
		`CHK("test kept", 7'h44, ft)
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		`CHK("trim rerst", 5'h10, trim)
		`CHK("range rerst", 2'h0, rng)
		`CHK("sp rd rerst", 16'h0000, rd_data)
		`CHK("bias rerst", 10'h000, bt)
		`CHK("mon rerst", 10'h000, mt)
		`CHK("cur rerst", 16'h0000, cur)
		`CHK("test rerst", 7'h44, ft)
		host_u.write(CMD_EDGE_TRIM, 16'h0003, 1'b0);
		`CHK("trim after rerst", 5'h03, trim)
		stop_test();
	end
endmodule
